//--- erasr_pkg.sv
package erasr_pkg;

  // Record population of the bank and its optional features
  localparam logic [15:0] NUM_RECORDS = 16'h0004;
  localparam logic HAS_SYNC_SOURCE = 1'h1;

  // System register keys: {op0, op1, CRn, CRm, op2}
  localparam logic [15:0] KEY_RECORD_COUNT = {2'h3, 3'h0, 4'h5, 4'h3, 3'h0};
  localparam logic [15:0] KEY_RECORD_SELECTOR =
    {2'h3, 3'h0, 4'h5, 4'h3, 3'h1};
  localparam logic [15:0] KEY_WINDOW_A = {2'h3, 3'h0, 4'h5, 4'h4, 3'h0};
  localparam logic [15:0] KEY_WINDOW_B = {2'h3, 3'h0, 4'h5, 4'h5, 3'h0};
  localparam logic [15:0] KEY_DEFERRED_STATUS =
    {2'h3, 3'h0, 4'hC, 4'h1, 3'h1};

  // Window register identifiers presented on the record port
  localparam logic [2:0] WIN_FEATURE = 3'h0;
  localparam logic [2:0] WIN_CONTROL = 3'h1;
  localparam logic [2:0] WIN_STATUS = 3'h2;
  localparam logic [2:0] WIN_ADDRESS = 3'h3;
  localparam logic [2:0] WIN_MISC_0 = 3'h4;
  localparam logic [2:0] WIN_MISC_1 = 3'h5;

  // Privilege levels
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;
  localparam logic [1:0] LVL_MON = 2'h3;

  // Deferred status field positions
  localparam int DS_PEND_BIT = 31;
  localparam int DS_FMT_BIT = 24;
  localparam int DS_IMPL_MSB = 23;
  localparam int DS_ERR_TYPE_MSB = 12;
  localparam int DS_ERR_TYPE_LSB = 10;
  localparam int DS_ABORT_TYPE_BIT = 9;
  localparam int DS_FSC_MSB = 5;

  // Reset values
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [63:0] DSTAT_RESET = 64'h0000_0000_0000_0000;

  // Outcome of an access, one-hot
  typedef enum logic [3:0] {
    EXC_NONE = 4'h1,
    EXC_UNDEF = 4'h2,
    EXC_TRAP_HYP = 4'h4,
    EXC_TRAP_MON = 4'h8
  } erasr_exc_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] key;
    logic [63:0] wdata;
  } erasr_req_t;

  typedef struct packed {
    logic [1:0] level;
    logic nonsecure;
    logic debug_state;
    logic hyp_present;
    logic mon_present;
    logic hyp_err_trap;
    logic mon_err_trap;
    logic hyp_abort_route;
    logic mon_ext_abort_route;
  } erasr_ctx_t;

  typedef struct packed {
    logic defer;
    logic fmt;
    logic [23:0] impl;
    logic [2:0] async_error_type;
    logic external_abort_type;
    logic [5:0] fsc;
  } erasr_barrier_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [2:0] win;
    logic [63:0] wdata;
  } erasr_rec_t;

  typedef struct packed {
    logic valid;
    logic claimed;
    erasr_exc_t exc;
    logic redirect;
    logic [63:0] rdata;
  } erasr_rsp_t;

endpackage

//--- erasr_bank.sv
`timescale 1ns/100ps
module erasr_bank (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  // Register access from the core
  input wire erasr_pkg::erasr_req_t req,
  input wire erasr_pkg::erasr_ctx_t ctx,
  // Barrier deferral event
  input wire erasr_pkg::erasr_barrier_t error_sync_barrier,
  // Record port
  output erasr_pkg::erasr_rec_t rec,
  input wire logic [63:0] rec_rdata,
  // Answer to the core
  output erasr_pkg::erasr_rsp_t rsp
);

  // Keeps only the defined deferred status fields
  function automatic logic [63:0] ds_clean(input logic [63:0] v);
    logic [63:0] o;
    o = 64'h0000_0000_0000_0000;
    o[erasr_pkg::DS_PEND_BIT] = v[erasr_pkg::DS_PEND_BIT] &
      erasr_pkg::HAS_SYNC_SOURCE;
    o[erasr_pkg::DS_FMT_BIT] = v[erasr_pkg::DS_FMT_BIT];
    if (v[erasr_pkg::DS_FMT_BIT]) begin
      o[erasr_pkg::DS_IMPL_MSB:0] = v[erasr_pkg::DS_IMPL_MSB:0];
    end else begin
      o[erasr_pkg::DS_ERR_TYPE_MSB:erasr_pkg::DS_ERR_TYPE_LSB] =
        v[erasr_pkg::DS_ERR_TYPE_MSB:erasr_pkg::DS_ERR_TYPE_LSB];
      o[erasr_pkg::DS_ABORT_TYPE_BIT] =
        v[erasr_pkg::DS_ABORT_TYPE_BIT];
      o[erasr_pkg::DS_FSC_MSB:0] = v[erasr_pkg::DS_FSC_MSB:0];
    end
    return o;
  endfunction

  logic [15:0] sel;
  logic [63:0] dstat;
  logic [15:0] next_sel;
  logic [63:0] next_dstat;
  logic is_count, is_sel, is_win, is_dstat, hit, in_range, go;
  logic redirect, ds_raz, ro_write;
  logic [2:0] win;
  logic [63:0] barrier_word, dstat_seen;
  logic barrier_event;
  erasr_pkg::erasr_exc_t exc;

  // Stage one holds the decoded access while the record port answers
  logic s1_valid, s1_claimed, s1_redirect, s1_use_rec;
  erasr_pkg::erasr_exc_t s1_exc;
  logic [63:0] s1_rdata;
  logic next_s1_valid, next_s1_claimed, next_s1_redirect, next_s1_use_rec;
  erasr_pkg::erasr_exc_t next_s1_exc;
  logic [63:0] next_s1_rdata;
  erasr_pkg::erasr_rec_t next_rec;
  erasr_pkg::erasr_rsp_t next_rsp;

  // Decode, privilege checks and architectural next values
  always_comb begin
    is_count = req.key == erasr_pkg::KEY_RECORD_COUNT;
    is_sel = req.key == erasr_pkg::KEY_RECORD_SELECTOR;
    is_win = (req.key[15:3] == erasr_pkg::KEY_WINDOW_A[15:3] &&
              req.key[2:0] <= 3'h3) ||
             (req.key[15:3] == erasr_pkg::KEY_WINDOW_B[15:3] &&
              req.key[2:0] <= 3'h1);
    win = (req.key[15:3] == erasr_pkg::KEY_WINDOW_A[15:3]) ?
      req.key[2:0] : erasr_pkg::WIN_MISC_0 + req.key[2:0];
    is_dstat = req.key == erasr_pkg::KEY_DEFERRED_STATUS;
    hit = is_count || is_sel || is_win || is_dstat;
    in_range = sel < erasr_pkg::NUM_RECORDS;
    ro_write = req.write &&
      (is_count || (is_win && win == erasr_pkg::WIN_FEATURE));
    redirect = is_dstat && ctx.hyp_present && ctx.hyp_abort_route &&
      ctx.level == erasr_pkg::LVL_KERNEL && ctx.nonsecure;
    ds_raz = is_dstat && !redirect && ctx.mon_present &&
      !ctx.debug_state && ctx.mon_ext_abort_route &&
      (ctx.level == erasr_pkg::LVL_KERNEL ||
       ctx.level == erasr_pkg::LVL_HYP);
    // Undefined outranks both traps; hypervisor trap outranks monitor trap
    if (ctx.level == erasr_pkg::LVL_USER || ro_write) begin
      exc = erasr_pkg::EXC_UNDEF;
    end else if (!is_dstat && ctx.hyp_present && ctx.hyp_err_trap &&
                 ctx.level == erasr_pkg::LVL_KERNEL && ctx.nonsecure) begin
      exc = erasr_pkg::EXC_TRAP_HYP;
    end else if (!is_dstat && ctx.mon_present && ctx.mon_err_trap &&
                 ctx.level != erasr_pkg::LVL_MON) begin
      exc = erasr_pkg::EXC_TRAP_MON;
    end else begin
      exc = erasr_pkg::EXC_NONE;
    end
    go = ce && req.valid && hit && exc == erasr_pkg::EXC_NONE;
    barrier_event = ce && error_sync_barrier.defer;
    barrier_word = ds_clean({32'h0000_0000, 1'h1, 6'h00,
      error_sync_barrier.fmt,
      error_sync_barrier.fmt ? error_sync_barrier.impl :
      {11'h000, error_sync_barrier.async_error_type,
       error_sync_barrier.external_abort_type, 3'h0,
       error_sync_barrier.fsc}});
    // A barrier in the same cycle is seen by a read and wins over a write
    dstat_seen = barrier_event ? barrier_word : dstat;
    next_sel = sel;
    if (go && is_sel && req.write &&
        erasr_pkg::NUM_RECORDS != 16'h0000) begin
      next_sel = req.wdata[15:0];
    end
    next_dstat = dstat;
    if (go && is_dstat && req.write && !redirect && !ds_raz) begin
      next_dstat = ds_clean(req.wdata);
    end
    if (barrier_event) begin
      next_dstat = barrier_word;
    end
  end

  // Architectural registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel <= erasr_pkg::SEL_RESET;
      dstat <= erasr_pkg::DSTAT_RESET;
    end else if (ce) begin
      sel <= next_sel;
      dstat <= next_dstat;
    end
  end

  // Stage one values and record port request
  always_comb begin
    next_s1_valid = req.valid;
    next_s1_claimed = hit;
    next_s1_exc = hit ? exc : erasr_pkg::EXC_NONE;
    next_s1_redirect = go && redirect;
    next_s1_use_rec = go && is_win && in_range && !req.write;
    next_s1_rdata = 64'h0000_0000_0000_0000;
    if (go && !req.write) begin
      if (is_count) begin
        next_s1_rdata = {48'h0000_0000_0000, erasr_pkg::NUM_RECORDS};
      end else if (is_sel) begin
        next_s1_rdata = {48'h0000_0000_0000, sel};
      end else if (is_dstat && !redirect && !ds_raz) begin
        next_s1_rdata = dstat_seen;
      end
    end
    next_rec.valid = go && is_win && in_range;
    next_rec.write = req.write;
    next_rec.index = sel;
    next_rec.win = win;
    next_rec.wdata = req.wdata;
  end

  // Stage one registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_valid <= 1'h0;
      s1_claimed <= 1'h0;
      s1_exc <= erasr_pkg::EXC_NONE;
      s1_redirect <= 1'h0;
      s1_use_rec <= 1'h0;
      s1_rdata <= 64'h0000_0000_0000_0000;
      rec <= '0;
    end else if (ce) begin
      s1_valid <= next_s1_valid;
      s1_claimed <= next_s1_claimed;
      s1_exc <= next_s1_exc;
      s1_redirect <= next_s1_redirect;
      s1_use_rec <= next_s1_use_rec;
      s1_rdata <= next_s1_rdata;
      rec <= next_rec;
    end
  end

  // Answer: record data is merged in the cycle it returns
  always_comb begin
    next_rsp.valid = s1_valid;
    next_rsp.claimed = s1_claimed;
    next_rsp.exc = s1_exc;
    next_rsp.redirect = s1_redirect;
    next_rsp.rdata = s1_use_rec ? rec_rdata : s1_rdata;
  end

  // Answer register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rsp <= '{valid: 1'h0, claimed: 1'h0, exc: erasr_pkg::EXC_NONE,
               redirect: 1'h0, rdata: 64'h0000_0000_0000_0000};
    end else if (ce) begin
      rsp <= next_rsp;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_user_undef;
    (ce && req.valid && hit && ctx.level == erasr_pkg::LVL_USER) ##1 ce
      |=> rsp.valid && rsp.exc == erasr_pkg::EXC_UNDEF;
  endproperty
  a_user_undef: assert property (p_user_undef)
    else $error("user level access not undefined");

  property p_count_read;
    (go && is_count && !req.write) ##1 ce |=>
      rsp.rdata == {48'h0000_0000_0000, erasr_pkg::NUM_RECORDS};
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("record count read wrong");

  property p_count_write;
    (ce && req.valid && is_count && req.write) ##1 ce
      |=> rsp.exc == erasr_pkg::EXC_UNDEF;
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("record count write not undefined");

  property p_hyp_trap;
    (ce && req.valid && (is_count || is_sel || is_win) && !ro_write &&
     ctx.level == erasr_pkg::LVL_KERNEL && ctx.nonsecure &&
     ctx.hyp_present && ctx.hyp_err_trap) ##1 ce
      |=> rsp.exc == erasr_pkg::EXC_TRAP_HYP && !$past(rec.valid);
  endproperty
  a_hyp_trap: assert property (p_hyp_trap)
    else $error("missing hypervisor trap");

  property p_mon_trap;
    (ce && req.valid && (is_count || is_sel || is_win) && !ro_write &&
     ctx.level == erasr_pkg::LVL_HYP && ctx.mon_present &&
     ctx.mon_err_trap) ##1 ce |=> rsp.exc == erasr_pkg::EXC_TRAP_MON;
  endproperty
  a_mon_trap: assert property (p_mon_trap)
    else $error("missing monitor trap");

  property p_redirect;
    (go && redirect) ##1 ce |=> rsp.redirect && rsp.rdata == 64'h0;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("deferred status not redirected");

  property p_dstat_raz;
    (go && ds_raz) |=> dstat == $past(dstat) || $past(barrier_event);
  endproperty
  a_dstat_raz: assert property (p_dstat_raz)
    else $error("deferred status write not ignored");

  property p_barrier_seen;
    (go && is_dstat && !req.write && !redirect && !ds_raz && barrier_event)
      ##1 ce |=> rsp.rdata[31] == erasr_pkg::HAS_SYNC_SOURCE &&
      rsp.rdata[24] == $past(error_sync_barrier.fmt, 2);
  endproperty
  a_barrier_seen: assert property (p_barrier_seen)
    else $error("barrier value not seen by read");

  property p_dstat_res0;
    dstat[63:32] == 32'h0 && dstat[30:25] == 6'h00 &&
      (dstat[24] || (dstat[23:13] == 11'h000 && dstat[8:6] == 3'h0));
  endproperty
  a_dstat_res0: assert property (p_dstat_res0)
    else $error("deferred status reserved bits set");

  property p_oor_raz;
    (go && is_win && !in_range) ##1 ce |=>
      !$past(rec.valid) && rsp.rdata == 64'h0;
  endproperty
  a_oor_raz: assert property (p_oor_raz)
    else $error("out-of-range window reached a record");

  property p_window_route;
    (go && is_win && in_range) |=> rec.valid &&
      rec.index == $past(sel) && rec.write == $past(req.write);
  endproperty
  a_window_route: assert property (p_window_route)
    else $error("window not routed to selected record");

  property p_sel_read;
    (go && is_sel && !req.write) ##1 ce |=>
      rsp.rdata == {48'h0000_0000_0000, $past(sel, 2)};
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("selector read-back wrong");

  property p_feature_ro;
    (ce && req.valid && is_win && win == erasr_pkg::WIN_FEATURE &&
     req.write) ##1 ce |=>
      rsp.exc == erasr_pkg::EXC_UNDEF && !$past(rec.valid);
  endproperty
  a_feature_ro: assert property (p_feature_ro)
    else $error("feature window write not refused");

  property p_sel_hold;
    !(go && is_sel && req.write) |=> sel == $past(sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("selector changed without a write");

  property p_refused_no_rec;
    (ce && req.valid && hit && exc != erasr_pkg::EXC_NONE) |=> !rec.valid;
  endproperty
  a_refused_no_rec: assert property (p_refused_no_rec)
    else $error("refused access reached a record");

  property p_redirect_keep;
    (go && redirect && !barrier_event) |=> dstat == $past(dstat);
  endproperty
  a_redirect_keep: assert property (p_redirect_keep)
    else $error("redirected access changed deferred status");

  property p_window_write;
    (go && is_win && in_range && req.write) |=> rec.write &&
      rec.wdata == $past(req.wdata) && rec.win == $past(win);
  endproperty
  a_window_write: assert property (p_window_write)
    else $error("window write not passed to the record");

  property p_barrier_arch;
    (barrier_event && !error_sync_barrier.fmt) |=>
      dstat[12:10] == $past(error_sync_barrier.async_error_type) &&
      dstat[9] == $past(error_sync_barrier.external_abort_type) &&
      dstat[5:0] == $past(error_sync_barrier.fsc) && !dstat[24];
  endproperty
  a_barrier_arch: assert property (p_barrier_arch)
    else $error("barrier syndrome fields misplaced");

  property p_barrier_impl;
    (barrier_event && error_sync_barrier.fmt) |=>
      dstat[23:0] == $past(error_sync_barrier.impl) && dstat[24];
  endproperty
  a_barrier_impl: assert property (p_barrier_impl)
    else $error("implementation syndrome not kept");

  c_window_read: cover property (go && is_win && in_range && !req.write);
  c_barrier_defer: cover property (barrier_event);
  c_oor_window: cover property (go && is_win && !in_range);
  c_hyp_trap: cover property (ce && exc == erasr_pkg::EXC_TRAP_HYP);
  c_redirect: cover property (go && redirect);

endmodule

//--- erasr_record_model.sv
`timescale 1ns/100ps
// Record store standing behind the window port of the bank
module erasr_record_model (
  // Clock
  input wire logic clock,
  // Record port from the bank
  input wire erasr_pkg::erasr_rec_t rec,
  output logic [63:0] rec_rdata
);
  logic [63:0] mem [0:3][0:5];
  logic [63:0] last;
  logic hit;

  // Known start pattern per record and window
  initial begin
    for (int i = 0; i < 4; i++) begin
      for (int w = 0; w < 6; w++) begin
        mem[i][w] = {48'hC0DE_0000_0000, i[7:0], w[7:0]};
      end
    end
    last = 64'h0;
  end

  // Only existing records and windows answer
  assign hit = rec.valid === 1'h1 && rec.index < 16'h4 && rec.win < 3'h6;

  // Store writes; remember the last value shown
  always @(posedge clock) begin
    if (hit && rec.write === 1'h1) begin
      mem[rec.index][rec.win] <= rec.wdata;
    end
    last <= rec_rdata;
  end

  // Data only while addressed, a changing pattern otherwise
  always_comb begin
    if (hit) begin
      rec_rdata = mem[rec.index][rec.win];
    end else begin
      rec_rdata = ~last;
    end
  end
endmodule

//--- erasr_bank_tb_top.sv
`timescale 1ns/100ps
module erasr_bank_tb_top;
  localparam logic [15:0] KC = erasr_pkg::KEY_RECORD_COUNT;
  localparam logic [15:0] KS = erasr_pkg::KEY_RECORD_SELECTOR;
  localparam logic [15:0] KD = erasr_pkg::KEY_DEFERRED_STATUS;
  localparam logic [1:0] KRN = erasr_pkg::LVL_KERNEL;
  localparam logic [1:0] HYP = erasr_pkg::LVL_HYP;
  localparam logic [1:0] USR = erasr_pkg::LVL_USER;
  localparam logic [1:0] MON = erasr_pkg::LVL_MON;
  // Key of the virtual deferred status, which another bank owns
  localparam logic [15:0] KV = {2'h3, 3'h4, 4'hC, 4'h1, 3'h1};
  localparam erasr_pkg::erasr_exc_t XN = erasr_pkg::EXC_NONE;
  localparam erasr_pkg::erasr_exc_t XU = erasr_pkg::EXC_UNDEF;
  localparam erasr_pkg::erasr_exc_t XH = erasr_pkg::EXC_TRAP_HYP;
  localparam erasr_pkg::erasr_exc_t XM = erasr_pkg::EXC_TRAP_MON;
  // Context flags: ns, dbg, hyp, mon, htrap, mtrap, hroute, mroute
  localparam logic [7:0] FB = 8'hB0;
  localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
  logic clock;
  logic sys_rst;
  logic ce;
  erasr_pkg::erasr_req_t req;
  erasr_pkg::erasr_ctx_t ctx;
  erasr_pkg::erasr_barrier_t error_sync_barrier;
  erasr_pkg::erasr_barrier_t barrier_next;
  logic claim_want;
  erasr_pkg::erasr_rec_t rec;
  logic [63:0] rec_rdata;
  erasr_pkg::erasr_rsp_t rsp;
  int err_count = 0;
  int num_checks = 0;
  int rec_cnt = 0;
  int base_cnt;

  erasr_bank u_erasr_bank (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .req(req), .ctx(ctx),
    .error_sync_barrier(error_sync_barrier), .rec(rec),
    .rec_rdata(rec_rdata), .rsp(rsp)
  );
  erasr_record_model u_erasr_record_model (
    .clock(clock), .rec(rec), .rec_rdata(rec_rdata)
  );

  // Clock and record pulse counter
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (rec.valid === 1'h1) rec_cnt++;
  end

  // Start pattern held by the record model
  function automatic logic [63:0] pat(input int i, input int w);
    return {48'hC0DE_0000_0000, i[7:0], w[7:0]};
  endfunction

  // Key of window w: feature, control, status, address, misc0, misc1
  function automatic logic [15:0] wkey(input int w);
    return (w < 4) ? erasr_pkg::KEY_WINDOW_A + 16'(w)
                   : erasr_pkg::KEY_WINDOW_B + 16'(w - 4);
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // One access; answer checked one edge after it is taken
  task automatic acc(input logic wr, input logic [15:0] k,
      input logic [63:0] wd, input logic [9:0] c,
      input erasr_pkg::erasr_exc_t ex, input logic [63:0] erd,
      input logic rdr);
    @(posedge clock);
    req <= '{valid: 1'h1, write: wr, key: k, wdata: wd};
    ctx <= c;
    error_sync_barrier <= barrier_next;
    @(posedge clock);
    req.valid <= 1'h0;
    error_sync_barrier <= '0;
    barrier_next = '0;
    @(posedge clock);
    #1;
    chk({57'h0, rsp.valid, rsp.claimed, rsp.redirect, rsp.exc},
        {57'h0, 1'h1, claim_want, rdr, ex});
    if (wr === 1'h0 && ex === XN) begin
      chk(rsp.rdata, erd);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clock = 1'h0;
    sys_rst = 1'h1;
    ce = 1'h1;
    req = '0;
    ctx = '0;
    error_sync_barrier = '0;
    barrier_next = '0;
    claim_want = 1'h1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'h0;
    acc(1'h0, KC, 0, {KRN, FB}, XN, 64'h4, 1'h0);
    acc(1'h1, KC, ONES, {KRN, FB}, XU, 0, 1'h0);
    acc(1'h0, KD, 0, {KRN, FB}, XN, 64'h0, 1'h0);
    acc(1'h1, KS, 64'hFFFF_FFFF_FFFF_0002, {KRN, FB}, XN, 0, 1'h0);
    acc(1'h0, KS, 0, {KRN, FB}, XN, 64'h2, 1'h0);
    // All windows of record 2, then write and read back
    for (int w = 0; w < 6; w++) begin
      acc(1'h0, wkey(w), 0, {KRN, FB}, XN, pat(2, w), 1'h0);
    end
    for (int w = 1; w < 6; w++) begin
      acc(1'h1, wkey(w), {56'h5A5A, w[7:0]}, {KRN, FB}, XN, 0, 1'h0);
      acc(1'h0, wkey(w), 0, {KRN, FB}, XN, {56'h5A5A, w[7:0]}, 1'h0);
    end
    acc(1'h1, wkey(0), ONES, {KRN, FB}, XU, 0, 1'h0);
    acc(1'h0, wkey(0), 0, {KRN, FB}, XN, pat(2, 0), 1'h0);
    acc(1'h1, KS, 64'h1, {KRN, FB}, XN, 0, 1'h0);
    acc(1'h0, wkey(3), 0, {KRN, FB}, XN, pat(1, 3), 1'h0);
    // Out-of-range selector: no record touched, reads zero
    acc(1'h1, KS, 64'h4, {KRN, FB}, XN, 0, 1'h0);
    acc(1'h0, KS, 0, {KRN, FB}, XN, 64'h4, 1'h0);
    base_cnt = rec_cnt;
    for (int w = 1; w < 6; w++) begin
      acc(1'h1, wkey(w), ONES, {KRN, FB}, XN, 0, 1'h0);
    end
    for (int w = 0; w < 6; w++) begin
      acc(1'h0, wkey(w), 0, {KRN, FB}, XN, 64'h0, 1'h0);
    end
    chk(64'(rec_cnt), 64'(base_cnt));
    acc(1'h1, KS, 64'h1, {KRN, FB}, XN, 0, 1'h0);
    acc(1'h0, wkey(4), 0, {KRN, FB}, XN, pat(1, 4), 1'h0);
    // Clock enable low: the selector write is not taken
    @(posedge clock);
    ce <= 1'h0;
    req <= '{valid: 1'h1, write: 1'h1, key: KS, wdata: 64'h3};
    ctx <= {KRN, FB};
    repeat (2) @(posedge clock);
    req.valid <= 1'h0;
    ce <= 1'h1;
    @(posedge clock);
    #1;
    chk({63'h0, rsp.valid}, 64'h0);
    acc(1'h0, KS, 0, {KRN, FB}, XN, 64'h1, 1'h0);
    // A key of another bank is not claimed and reads zero
    claim_want = 1'h0;
    acc(1'h0, KV, 0, {KRN, 8'hB2}, XN, 64'h0, 1'h0);
    claim_want = 1'h1;
    // Privilege and traps
    acc(1'h0, KC, 0, {USR, FB}, XU, 0, 1'h0);
    acc(1'h0, KD, 0, {USR, FB}, XU, 0, 1'h0);
    acc(1'h0, KS, 0, {USR, 8'hBC}, XU, 0, 1'h0);
    acc(1'h0, KS, 0, {KRN, 8'hB8}, XH, 0, 1'h0);
    acc(1'h1, wkey(3), ONES, {KRN, 8'hB8}, XH, 0, 1'h0);
    acc(1'h0, KS, 0, {KRN, 8'h38}, XN, 64'h1, 1'h0);
    acc(1'h0, KC, 0, {HYP, 8'hB8}, XN, 64'h4, 1'h0);
    acc(1'h0, KC, 0, {HYP, 8'hB4}, XM, 0, 1'h0);
    acc(1'h0, wkey(3), 0, {KRN, 8'h34}, XM, 0, 1'h0);
    acc(1'h0, KS, 0, {KRN, 8'hBC}, XH, 0, 1'h0);
    acc(1'h0, KS, 0, {MON, 8'hBC}, XN, 64'h1, 1'h0);
    // Barrier deferral seen by a read in the same cycle
    barrier_next = {1'h1, 1'h0, 24'hFF_FFFF, 3'h5, 1'h1, 6'h11};
    acc(1'h0, KD, 0, {KRN, FB}, XN, 64'h8000_1611, 1'h0);
    barrier_next = {1'h1, 1'h1, 24'hAB_CDEF, 3'h7, 1'h1, 6'h3F};
    acc(1'h0, KD, 0, {KRN, FB}, XN, 64'h81AB_CDEF, 1'h0);
    acc(1'h1, KD, ONES, {KRN, FB}, XN, 0, 1'h0);
    acc(1'h0, KD, 0, {KRN, FB}, XN, 64'h81FF_FFFF, 1'h0);
    // Virtual redirect and monitor routing
    acc(1'h0, KD, 0, {KRN, 8'hB2}, XN, 64'h0, 1'h1);
    acc(1'h1, KD, 64'h0, {KRN, 8'hB2}, XN, 0, 1'h1);
    acc(1'h0, KD, 0, {HYP, 8'hB2}, XN, 64'h81FF_FFFF, 1'h0);
    acc(1'h0, KD, 0, {KRN, 8'h31}, XN, 64'h0, 1'h0);
    acc(1'h1, KD, 64'h0, {HYP, 8'h31}, XN, 0, 1'h0);
    acc(1'h0, KD, 0, {KRN, 8'h71}, XN, 64'h81FF_FFFF, 1'h0);
    stop_test();
  end
endmodule
